// [asr_codec_model.sv]
// far-side model: codec framing words onto the receive pins
`timescale 1ns/1ps

module asr_codec_model (
    // pins towards the receiver
    output logic sck,
    output logic ws,
    output logic [1:0] sdi
);
    // clock parked low, select at right level so a left word makes an edge
    initial begin
        sck = 1'b0;
        ws = 1'b1;
        sdi = 2'b00;
    end

    // one word msb first; receiver one gets the inverted bits
    task automatic word(input logic lvl, input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            ws = lvl; // select edge with the first bit
            sdi = {~w[i], w[i]}; // change while clock low
            #24 sck = 1'b1; // sampled on this rise
            #24 sck = 1'b0;
        end
        sdi = ~sdi; // released lines show no stale bit
    endtask : word
endmodule : asr_codec_model

// [asr_pkg.sv]
// package: register map, field layout, word lengths and state carrier of the receive section
package asr_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00; // control and status word
    localparam logic [7:0] ADDR_DATA_ZERO = 8'h04; // receiver zero data
    localparam logic [7:0] ADDR_DATA_ONE = 8'h08; // receiver one data

    //////////////////////////////////////////////////////////////////////////
    // control/status bit positions
    localparam int BIT_EN0 = 0;
    localparam int BIT_EN1 = 1;
    localparam int BIT_MASTER = 3;
    localparam int BIT_WL_LO = 4;
    localparam int BIT_WL_HI = 5;
    localparam int BIT_ORDER = 6;
    localparam int BIT_LR_POL = 7;
    localparam int BIT_CLK_POL = 8;
    localparam int BIT_REL = 9;
    localparam int BIT_TRUNC = 10;
    localparam int BIT_INT_EN = 11;
    localparam int BIT_VEC_LOC = 12;
    localparam int BIT_LEFT_FULL = 14;
    localparam int BIT_RIGHT_FULL = 15;

    //////////////////////////////////////////////////////////////////////////
    // word length codes and bit counts
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_24 = 2'h1;
    localparam logic [1:0] WL_32 = 2'h2;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] BITS_32 = 6'h20;
    localparam logic [5:0] BITS_NONE = 6'h00; // reserved code never completes
    localparam logic [5:0] BITS_MAX = 6'h3f;
    localparam logic [5:0] BIT_ONE = 6'h01;
    localparam logic [7:0] LOW_PAD = 8'h00; // cleared low byte in 16-bit mode

    //////////////////////////////////////////////////////////////////////////
    // interrupt vector addresses
    localparam logic [7:0] VEC_LEFT_LO = 8'h16;
    localparam logic [7:0] VEC_RIGHT_LO = 8'h18;
    localparam logic [7:0] VEC_EXC_LO = 8'h1a;
    localparam logic [7:0] VEC_LEFT_HI = 8'h46;
    localparam logic [7:0] VEC_RIGHT_HI = 8'h48;
    localparam logic [7:0] VEC_EXC_HI = 8'h4a;
    localparam logic [7:0] VEC_NONE = 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // control fields, msb first as they sit in the word
    typedef struct packed {
        logic vector_location;
        logic interrupt_enable;
        logic truncation_select;
        logic relative_timing;
        logic clock_polarity;
        logic left_right_polarity;
        logic bit_order;
        logic [1:0] word_length;
        logic master_select;
        logic enable_one;
        logic enable_zero;
    } asr_ctrl_t;

    // whole state of the receive section
    typedef struct packed {
        asr_ctrl_t ctrl;
        logic left_full;
        logic right_full;
        logic overrun_armed;
        logic [1:0] read_seen;
        logic enable_dly;
        logic int_en_dly;
        logic [1:0] sck_sync;
        logic [1:0] ws_sync;
        logic [1:0] sdi0_sync;
        logic [1:0] sdi1_sync;
        logic sck_prev;
        logic [7:0] div_cnt;
        logic gen_sck;
        logic gen_ws;
        logic [5:0] gen_bits;
        logic [5:0] bit_cnt;
        logic word_ws;
        logic prev_ws;
        logic pending_start;
        logic framed;
        logic [31:0] shift0;
        logic [31:0] shift1;
        logic [23:0] data0;
        logic [23:0] data1;
        logic [31:0] rdata;
        logic ack;
        logic slverr;
    } asr_state_t;

endpackage : asr_pkg

// [asr_receiver.sv]
// receive section of the serial audio port: apb registers, serial capture, vectored requests
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps

module asr_receiver #(
    parameter int CLK_HALF = 8 // pclk cycles per half serial clock in master mode
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core state
    input wire logic soft_reset,
    input wire logic core_stop,
    // serial clock pin
    input wire logic receive_serial_clock_in,
    output logic receive_serial_clock_out,
    output logic receive_serial_clock_oe,
    // word select pin
    input wire logic receive_word_select_in,
    output logic receive_word_select_out,
    output logic receive_word_select_oe,
    // serial data pins, one per receiver
    input wire logic [1:0] serial_data_inputs,
    // vectored interrupt requests
    output logic irq_left,
    output logic irq_right,
    output logic irq_overrun,
    output logic [7:0] irq_vector
);

    //////////////////////////////////////////////////////////////////////////
    // elaboration check: synchronised data needs a few cycles of margin
    if (CLK_HALF < 4 || CLK_HALF > 255) begin : g_bad_half
        $error("CLK_HALF must lie between 4 and 255");
    end

    localparam logic [7:0] HALF_LAST = 8'(CLK_HALF - 1);

    //////////////////////////////////////////////////////////////////////////
    // word length code to bit count
    function automatic logic [5:0] word_bits(input logic [1:0] wl);
        case (wl)
            asr_pkg::WL_16: word_bits = asr_pkg::BITS_16;
            asr_pkg::WL_24: word_bits = asr_pkg::BITS_24;
            asr_pkg::WL_32: word_bits = asr_pkg::BITS_32;
            default: word_bits = asr_pkg::BITS_NONE;
        endcase
    endfunction : word_bits

    // pick the 24 data bits out of a finished shift register
    function automatic logic [23:0] extract(input logic [31:0] s, input asr_pkg::asr_ctrl_t c);
        logic take_high;
        take_high = ~(c.bit_order ^ c.truncation_select);
        case (c.word_length)
            // the 16 received bits, placed in the upper 16 whatever the order, low byte cleared
            asr_pkg::WL_16: extract = c.bit_order ? {s[31:16], asr_pkg::LOW_PAD}
                                                  : {s[15:0], asr_pkg::LOW_PAD};
            asr_pkg::WL_24: extract = c.bit_order ? s[31:8] : s[23:0];
            // first or last 24 of the 32 received bits
            asr_pkg::WL_32: extract = take_high ? s[31:8] : s[23:0];
            default: extract = '0;
        endcase
    endfunction : extract

    //////////////////////////////////////////////////////////////////////////
    // state and helpers
    asr_pkg::asr_state_t s; // registered state
    asr_pkg::asr_state_t next_s; // next state
    logic done; // apb access completes this edge
    logic irq_en; // interrupt enable with delayed fall
    logic left_level; // word-select level marking a left word

    assign done = psel & penable & s.ack;
    // falling enable still counts for one more cycle
    assign irq_en = s.ctrl.interrupt_enable | s.int_en_dly;
    // polarity bit swaps the left level
    assign left_level = s.ctrl.left_right_polarity;

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic active; // section out of individual reset
        logic sample; // sampling edge of the serial clock
        logic ws_now; // sampled word-select
        logic ws_chg; // word-select changed since last sample
        logic start; // this bit opens a word
        logic left_word; // current word is left
        logic [5:0] cnt_after; // bits in word including this one
        logic [5:0] nbits; // selected word length
        logic [31:0] sh0; // shifted receiver zero
        logic [31:0] sh1; // shifted receiver one
        logic xfer; // whole word assembled
        logic set_left; // left word transferred
        logic set_right; // right word transferred
        logic [1:0] en; // receiver enables
        logic [1:0] seen; // enabled receivers read so far
        logic gen_change; // generator reaches its change edge
        logic gen_sample; // generator reaches its sampling edge
        active = 1'b0;
        sample = 1'b0;
        ws_now = 1'b0;
        ws_chg = 1'b0;
        start = 1'b0;
        left_word = 1'b0;
        cnt_after = '0;
        xfer = 1'b0;
        set_left = 1'b0;
        set_right = 1'b0;
        gen_change = 1'b0;
        gen_sample = 1'b0;
        next_s = s;
        en = {s.ctrl.enable_one, s.ctrl.enable_zero};
        seen = s.read_seen;
        nbits = word_bits(s.ctrl.word_length);
        sh0 = s.shift0;
        sh1 = s.shift1;

        // pin synchronisers, the first stage feeds only the second
        next_s.sck_sync = {s.sck_sync[0], receive_serial_clock_in};
        next_s.ws_sync = {s.ws_sync[0], receive_word_select_in};
        next_s.sdi0_sync = {s.sdi0_sync[0], serial_data_inputs[0]};
        next_s.sdi1_sync = {s.sdi1_sync[0], serial_data_inputs[1]};
        next_s.sck_prev = s.sck_sync[1];

        // individual reset follows the enables one cycle late
        next_s.enable_dly = s.ctrl.enable_zero | s.ctrl.enable_one;
        active = s.enable_dly;
        next_s.int_en_dly = s.ctrl.interrupt_enable;

        ////////////////////////////////////////////////////////////////////
        // master clock and word-select generator
        if (s.ctrl.master_select && active) begin
            if (s.div_cnt == HALF_LAST) begin
                next_s.div_cnt = '0;
                next_s.gen_sck = ~s.gen_sck;
                // change edge when clock moves to its polarity level
                gen_change = (~s.gen_sck == s.ctrl.clock_polarity);
                gen_sample = ~gen_change;
            end else begin
                next_s.div_cnt = s.div_cnt + 8'h01;
            end
            if (gen_change) begin
                // bit index wraps at the word length
                next_s.gen_bits = s.gen_bits + asr_pkg::BIT_ONE;
                if (s.gen_bits + asr_pkg::BIT_ONE >= nbits) begin
                    next_s.gen_bits = '0;
                end
                // toggle at first bit, or one bit earlier
                if (s.ctrl.relative_timing
                        ? (s.gen_bits + asr_pkg::BIT_ONE == nbits - asr_pkg::BIT_ONE)
                        : (next_s.gen_bits == '0)) begin
                    next_s.gen_ws = ~s.gen_ws;
                end
            end
        end else begin
            // idle: clock parked, first word announced as left
            next_s.div_cnt = '0;
            next_s.gen_sck = s.ctrl.clock_polarity;
            next_s.gen_ws = left_level;
            next_s.gen_bits = '0;
        end

        ////////////////////////////////////////////////////////////////////
        // sampling edge from generator or from the pin
        if (s.ctrl.master_select) begin
            sample = gen_sample;
            ws_now = s.gen_ws;
        end else begin
            sample = s.ctrl.clock_polarity ? (~s.sck_sync[1] & s.sck_prev)
                                           : (s.sck_sync[1] & ~s.sck_prev);
            ws_now = s.ws_sync[1];
        end

        ////////////////////////////////////////////////////////////////////
        // shared word controller for both receivers
        if (!active) begin
            // no framing until a left word opens after enabling
            next_s.framed = 1'b0;
            next_s.bit_cnt = '0;
            next_s.pending_start = 1'b0;
            next_s.prev_ws = s.ctrl.master_select ? ~left_level : s.ws_sync[1];
        end else if (sample) begin
            ws_chg = ws_now ^ s.prev_ws;
            next_s.prev_ws = ws_now;
            next_s.pending_start = ws_chg;
            // select edge marks this bit or the next as first
            start = s.ctrl.relative_timing ? s.pending_start : ws_chg;
            // shift direction
            sh0 = s.ctrl.bit_order ? {s.sdi0_sync[1], s.shift0[31:1]}
                                   : {s.shift0[30:0], s.sdi0_sync[1]};
            sh1 = s.ctrl.bit_order ? {s.sdi1_sync[1], s.shift1[31:1]}
                                   : {s.shift1[30:0], s.sdi1_sync[1]};
            next_s.shift0 = sh0;
            next_s.shift1 = sh1;
            if (start) begin
                cnt_after = asr_pkg::BIT_ONE;
                next_s.word_ws = ws_now;
                left_word = (ws_now == left_level);
                next_s.framed = s.framed | left_word;
            end else begin
                cnt_after = (s.bit_cnt == asr_pkg::BITS_MAX) ? s.bit_cnt
                                                              : s.bit_cnt + asr_pkg::BIT_ONE;
                left_word = (s.word_ws == left_level);
            end
            next_s.bit_cnt = cnt_after;
            xfer = next_s.framed && (cnt_after == nbits);
        end

        ////////////////////////////////////////////////////////////////////
        // word transfer into the data registers
        if (xfer) begin
            if (s.ctrl.enable_zero) begin
                next_s.data0 = extract(sh0, s.ctrl);
            end
            if (s.ctrl.enable_one) begin
                next_s.data1 = extract(sh1, s.ctrl);
            end
            set_left = left_word;
            set_right = ~left_word;
        end

        ////////////////////////////////////////////////////////////////////
        // apb: one wait state, then the access completes
        next_s.ack = psel & penable & ~s.ack;
        if (psel && penable && !s.ack) begin
            next_s.slverr = 1'b0;
            case (paddr)
                asr_pkg::ADDR_CTRL_STATUS: begin
                    next_s.rdata = '0;
                    next_s.rdata[asr_pkg::BIT_RIGHT_FULL:0] =
                        {s.right_full, s.left_full, 1'b0, s.ctrl[11:2], 1'b0, s.ctrl[1:0]};
                end
                asr_pkg::ADDR_DATA_ZERO: next_s.rdata = {8'h00, s.data0};
                asr_pkg::ADDR_DATA_ONE: next_s.rdata = {8'h00, s.data1};
                default: begin
                    // unmapped: zero data and an error answer
                    next_s.rdata = '0;
                    next_s.slverr = 1'b1;
                end
            endcase
        end

        // register effects at completion
        if (done) begin
            if (pwrite) begin
                if (paddr == asr_pkg::ADDR_CTRL_STATUS) begin
                    // status bits and reserved bits ignore writes
                    next_s.ctrl = {pwdata[asr_pkg::BIT_VEC_LOC:asr_pkg::BIT_MASTER],
                                   pwdata[asr_pkg::BIT_EN1:asr_pkg::BIT_EN0]};
                end
            end else begin
                case (paddr)
                    asr_pkg::ADDR_CTRL_STATUS: begin
                        // status read during overrun arms the clear
                        if (s.left_full && s.right_full) begin
                            next_s.overrun_armed = 1'b1;
                        end
                    end
                    asr_pkg::ADDR_DATA_ZERO: seen[0] = seen[0] | en[0];
                    asr_pkg::ADDR_DATA_ONE: seen[1] = seen[1] | en[1];
                    default: seen = s.read_seen;
                endcase
                if (paddr == asr_pkg::ADDR_DATA_ZERO || paddr == asr_pkg::ADDR_DATA_ONE) begin
                    if (s.left_full ^ s.right_full) begin
                        // single flag goes on the data read
                        next_s.left_full = 1'b0;
                        next_s.right_full = 1'b0;
                        seen = '0;
                    end else if (s.overrun_armed && ((seen & en) == en)) begin
                        // status read has armed the clear and all enabled data registers are read since the last word
                        next_s.left_full = 1'b0;
                        next_s.right_full = 1'b0;
                        next_s.overrun_armed = 1'b0;
                        seen = '0;
                    end
                end
            end
        end
        next_s.read_seen = seen;

        // a new word restarts the read tracking
        if (xfer) begin
            next_s.read_seen = '0;
        end
        // hardware sets win over software clears
        if (set_left) begin
            next_s.left_full = 1'b1;
        end
        if (set_right) begin
            next_s.right_full = 1'b1;
        end

        // stop and individual reset clear status only
        if (core_stop || !active) begin
            next_s.left_full = 1'b0;
            next_s.right_full = 1'b0;
            next_s.overrun_armed = 1'b0;
            next_s.read_seen = '0;
        end

        // software reset clears every field
        if (soft_reset) begin
            next_s = '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // state register, hardware reset clears all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = s.rdata;
    assign pready = s.ack;
    assign pslverr = s.ack & s.slverr;
    // pins driven only as master
    assign receive_serial_clock_out = s.gen_sck;
    assign receive_serial_clock_oe = s.ctrl.master_select;
    assign receive_word_select_out = s.gen_ws;
    assign receive_word_select_oe = s.ctrl.master_select;

    // vectored requests from the two flags
    assign irq_left = irq_en & s.left_full & ~s.right_full;
    assign irq_right = irq_en & ~s.left_full & s.right_full;
    assign irq_overrun = irq_en & s.left_full & s.right_full;

    // vector address by location bit
    always_comb begin
        if (irq_overrun) begin
            irq_vector = s.ctrl.vector_location ? asr_pkg::VEC_EXC_HI : asr_pkg::VEC_EXC_LO;
        end else if (irq_left) begin
            irq_vector = s.ctrl.vector_location ? asr_pkg::VEC_LEFT_HI : asr_pkg::VEC_LEFT_LO;
        end else if (irq_right) begin
            irq_vector = s.ctrl.vector_location ? asr_pkg::VEC_RIGHT_HI : asr_pkg::VEC_RIGHT_LO;
        end else begin
            irq_vector = asr_pkg::VEC_NONE;
        end
    end

endmodule : asr_receiver

// [asr_receiver_properties.sv]
// checker: port-level properties of the serial receive section
`timescale 1ns/1ps

module asr_receiver_properties (
    // clock, reset, core state
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic core_stop,
    // pin enables
    input wire logic receive_serial_clock_oe,
    input wire logic receive_word_select_oe,
    // requests
    input wire logic irq_left,
    input wire logic irq_right,
    input wire logic irq_overrun,
    input wire logic [7:0] irq_vector
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // no request and no vector
    sequence s_quiet;
        !irq_left && !irq_right && !irq_overrun && irq_vector == 8'h00;
    endsequence

    a_pins_together: assert property (
        receive_serial_clock_oe == receive_word_select_oe) else $error("pin enables differ");
    a_left_vector: assert property (
        irq_left |-> irq_vector inside {8'h16, 8'h46}) else $error("left vector wrong");
    a_right_vector: assert property (
        irq_right |-> irq_vector inside {8'h18, 8'h48}) else $error("right vector wrong");
    a_overrun_vector: assert property (
        irq_overrun |-> irq_vector inside {8'h1a, 8'h4a}) else $error("overrun vector wrong");
    a_single_request: assert property (
        $onehot0({irq_left, irq_right, irq_overrun})) else $error("several requests");
    a_idle_vector: assert property (
        !(irq_left || irq_right || irq_overrun) |-> s_quiet) else $error("stray vector");
    a_soft_clear: assert property (
        soft_reset |=> s_quiet ##0 !receive_serial_clock_oe) else $error("soft reset kept state");
    a_stop_clear: assert property (
        core_stop |=> s_quiet) else $error("stop kept a request");
endmodule : asr_receiver_properties

bind asr_receiver asr_receiver_properties asr_receiver_properties_i (
    .pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .core_stop(core_stop),
    .receive_serial_clock_oe(receive_serial_clock_oe),
    .receive_word_select_oe(receive_word_select_oe), .irq_left(irq_left),
    .irq_right(irq_right), .irq_overrun(irq_overrun), .irq_vector(irq_vector));

// [asr_receiver_tb.sv]
// testbench: register and serial scenarios for the receive section
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module asr_receiver_tb;
    // design inputs and outputs
    logic pclk, presetn, soft_reset, core_stop, psel, penable, pwrite, pready, pslverr, errv;
    logic [7:0] paddr, vec;
    logic [31:0] pwdata, prdata, rdv;
    logic sck, ws, sck_o, sck_oe, ws_o, ws_oe, irq_l, irq_r, irq_o, prev, ws_seen;
    logic [1:0] sdi;
    int bad_count, checks_done, edges;

    asr_receiver #(.CLK_HALF(4)) asr_receiver_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
        .core_stop(core_stop), .receive_serial_clock_in(sck), .receive_serial_clock_out(sck_o),
        .receive_serial_clock_oe(sck_oe), .receive_word_select_in(ws),
        .receive_word_select_out(ws_o), .receive_word_select_oe(ws_oe),
        .serial_data_inputs(sdi), .irq_left(irq_l), .irq_right(irq_r), .irq_overrun(irq_o),
        .irq_vector(vec));
    asr_codec_model asr_codec_model_i (.sck(sck), .ws(ws), .sdi(sdi));

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // apb transfer: setup, access until ready, one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // expected data register contents
    function automatic logic [23:0] exp_word(logic [31:0] w, int n, bit rev, bit t);
        logic [31:0] v;
        v = w;
        for (int i = 0; i < n; i++) if (rev) v[i] = w[n - 1 - i];
        if (n == 16) return {v[15:0], 8'h00};
        return (n == 24 || t) ? v[23:0] : v[31:8];
    endfunction : exp_word

    task automatic irq_is(input logic [2:0] e, input logic [7:0] v);
        `CHK({irq_l, irq_r, irq_o}, e)
        `CHK(vec, v)
    endtask : irq_is

    task automatic send(input logic lvl, input logic [31:0] w, input int n);
        asr_codec_model_i.word(lvl, w, n);
        repeat (8) @(posedge pclk);
    endtask : send

    task automatic data_is(input logic [31:0] w, input int n, input bit rev, input bit t);
        apb(1'b0, asr_pkg::ADDR_DATA_ZERO, 32'h0);
        `CHK(rdv, {8'h00, exp_word(w, n, rev, t)})
        apb(1'b0, asr_pkg::ADDR_DATA_ONE, 32'h0);
        `CHK(rdv, {8'h00, exp_word(~w, n, rev, t)})
    endtask : data_is

    task automatic give_verdict;
        $display("mismatches=%0d checks=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {presetn, soft_reset, core_stop, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdv, 32'h0000_0000)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(errv, 1'b1)
        apb(1'b1, 8'h00, 32'h0000_c803);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdv, 32'h0000_0803)
        send(1'b0, 32'h0000_a5c3, 16);
        irq_is(3'b100, 8'h16);
        data_is(32'h0000_a5c3, 16, 1'b0, 1'b0);
        irq_is(3'b000, 8'h00);
        send(1'b1, 32'h0000_3c5a, 16);
        irq_is(3'b010, 8'h18);
        send(1'b0, 32'h0000_0f0f, 16);
        irq_is(3'b001, 8'h1a);
        apb(1'b0, 8'h00, 32'h0);
        data_is(32'h0000_0f0f, 16, 1'b0, 1'b0);
        irq_is(3'b000, 8'h00);
        send(1'b1, 32'h0000_1111, 16);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdv[15:14], 2'b00)
        apb(1'b1, 8'h00, 32'h0000_1853);
        send(1'b0, 32'h00ab_cdef, 24);
        irq_is(3'b100, 8'h46);
        apb(1'b1, 8'h00, 32'h0000_1053);
        irq_is(3'b100, 8'h46);
        @(posedge pclk);
        irq_is(3'b000, 8'h00);
        core_stop <= 1'b1;
        @(posedge pclk);
        core_stop <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdv[15:0], 16'h1053)
        data_is(32'h00ab_cdef, 24, 1'b1, 1'b0);
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h00, 32'h0000_00a3 | (t << 10));
            send(1'b0, 32'h89ab_cdef, 32);
            send(1'b1, 32'h89ab_cdef, 32);
            apb(1'b0, 8'h00, 32'h0);
            `CHK(rdv[15:14], 2'b01)
            irq_is(3'b000, 8'h00);
            data_is(32'h89ab_cdef, 32, 1'b0, t[0]);
        end
        apb(1'b1, 8'h00, 32'h0000_000b);
        ws_seen = ws_o;
        do @(posedge pclk); while (ws_o === ws_seen);
        ws_seen = ws_o;
        edges = 0;
        prev = sck_o;
        do begin
            @(posedge pclk);
            edges += int'(sck_o !== prev);
            prev = sck_o;
        end while (ws_o === ws_seen);
        `CHK({sck_oe, ws_oe, edges}, {2'b11, 32'd32})
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK({rdv, sck_oe}, 33'h0)
        give_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule : asr_receiver_tb
